// >>> src/qbio_ports.sv
// top: bus port (open drain as I/O, push-pull as bus) and two quasi-bidirectional ports
`timescale 1ns/100ps
`default_nettype none
module qbio_ports #(
  parameter int BOOST_CYC = qbio_pkg::QBIO_BOOST_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             p0_wr,
  input  wire logic [7:0]       p0_wdata,
  input  wire logic             p1_wr,
  input  wire logic [7:0]       p1_wdata,
  input  wire logic             p2_wr,
  input  wire logic [7:0]       p2_wdata,
  input  wire qbio_pkg::qbio_bus_t bus,
  input  wire logic             serial1_transmit_out,
  input  wire logic             timer2_out_en,
  input  wire logic             timer2_out,
  input  wire logic [7:0]       p0_in,
  input  wire logic [7:0]       p1_in,
  input  wire logic [7:0]       p2_in,
  output qbio_pkg::qbio_drv_t   p0_drv,
  output qbio_pkg::qbio_qdrv_t  p1_drv,
  output qbio_pkg::qbio_qdrv_t  p2_drv,
  output logic [7:0]            p0_rd,
  output logic [7:0]            p1_rd,
  output logic [7:0]            p2_rd,
  output logic [7:0]            muxed_addr_data_low,
  output logic                  timer2_ext_io,
  output logic                  timer2_capture_reload_trigger,
  output logic                  serial1_receive_in,
  output logic                  ext_irq_b_rising,
  output logic                  ext_irq_c_falling,
  output logic                  ext_irq_d_rising,
  output logic                  ext_irq_e_falling
);
  import qbio_pkg::*;
  qbio_drv_t  p0_r, p0_nxt;
  logic [7:0] p0_latch_r, p0_latch_nxt;
  logic [7:0] p1_alt, p2_alt;
  logic [7:0] p1_latch, p2_latch, p1_lv, p2_lv;
  logic [7:0] in1_r, in1_nxt, prev1_r, prev1_nxt;
  logic [7:0] rd0_r, rd1_r, rd2_r, ad_r;
  logic [3:0] irq_r, irq_nxt;
  logic [2:0] alt_r, alt_nxt;

  // first port: open drain as I/O, push-pull as bus
  always_comb begin
    p0_latch_nxt = p0_wr ? p0_wdata : p0_latch_r;
    p0_nxt.dout  = 8'h00;
    p0_nxt.oe_n  = p0_latch_nxt; // only low is driven as plain I/O
    if (bus.ale) begin
      p0_nxt.dout = bus.addr_low;
      p0_nxt.oe_n = 8'h00;
    end else if (bus.drive_data) begin
      p0_nxt.dout = bus.wdata;
      p0_nxt.oe_n = 8'h00;
    end else if (bus.ext_access) begin
      p0_nxt.oe_n = 8'hff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      p0_latch_r <= QBIO_LATCH_RST;
      p0_r <= '{dout: 8'h00, oe_n: 8'hff};
    end else begin
      p0_latch_r <= p0_latch_nxt;
      p0_r <= p0_nxt;
    end
  end

  // alternate outputs pull low only where the function wants a zero
  always_comb begin
    p1_alt = 8'h00;
    p1_alt[QBIO_TX] = !serial1_transmit_out;
    p1_alt[QBIO_T2_IO] = timer2_out_en && !timer2_out;
    p2_alt = bus.ext_access ? ~bus.addr_high : 8'h00;
  end

  qbio_qport #(.BOOST_CYC(BOOST_CYC)) u_p1 (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .wr       (p1_wr),
    .wdata    (p1_wdata),
    .alt_low  (p1_alt),
    .pin_in   (p1_in),
    .latch    (p1_latch),
    .rd_level (p1_lv),
    .drv      (p1_drv)
  );

  qbio_qport #(.BOOST_CYC(BOOST_CYC)) u_p2 (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .wr       (p2_wr),
    .wdata    (p2_wdata),
    .alt_low  (p2_alt),
    .pin_in   (p2_in),
    .latch    (p2_latch),
    .rd_level (p2_lv),
    .drv      (p2_drv)
  );

  // second-port inputs and edge detectors
  always_comb begin
    in1_nxt   = p1_lv;
    prev1_nxt = in1_r;
    irq_nxt[0] = in1_r[QBIO_IRQ_B] && !prev1_r[QBIO_IRQ_B];
    irq_nxt[1] = !in1_r[QBIO_IRQ_C] && prev1_r[QBIO_IRQ_C];
    irq_nxt[2] = in1_r[QBIO_IRQ_D] && !prev1_r[QBIO_IRQ_D];
    irq_nxt[3] = !in1_r[QBIO_IRQ_E] && prev1_r[QBIO_IRQ_E];
    alt_nxt = {in1_r[QBIO_RX], in1_r[QBIO_T2_TRIG],
               in1_r[QBIO_T2_IO]};
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in1_r   <= 8'hff;
      prev1_r <= 8'hff;
      irq_r   <= 4'h0;
      alt_r   <= 3'h7;
      rd0_r   <= 8'h00;
      rd1_r   <= 8'hff;
      rd2_r   <= 8'hff;
      ad_r    <= 8'h00;
    end else begin
      in1_r   <= in1_nxt;
      prev1_r <= prev1_nxt;
      irq_r   <= irq_nxt;
      alt_r   <= alt_nxt;
      rd0_r   <= p0_in;
      rd1_r   <= p1_lv;
      rd2_r   <= p2_lv;
      ad_r    <= p0_in;
    end
  end

  assign p0_drv = p0_r;
  assign p0_rd  = rd0_r;
  assign p1_rd  = rd1_r;
  assign p2_rd  = rd2_r;
  assign muxed_addr_data_low = ad_r;
  assign timer2_ext_io = alt_r[0];
  assign timer2_capture_reload_trigger = alt_r[1];
  assign serial1_receive_in = alt_r[2];
  assign ext_irq_b_rising  = irq_r[0];
  assign ext_irq_c_falling = irq_r[1];
  assign ext_irq_d_rising  = irq_r[2];
  assign ext_irq_e_falling = irq_r[3];

  // consecutive boost cycles on one pin; saturates rather than wraps
  logic [3:0] boost_run_r, boost_run_nxt;

  always_comb begin
    boost_run_nxt = 4'h0;
    if (!p1_drv.boost_n[7])
      boost_run_nxt = (boost_run_r == 4'hf) ? boost_run_r
                                             : boost_run_r + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      boost_run_r <= 4'h0;
    else
      boost_run_r <= boost_run_nxt;
  end

  reset_tristate_a: assert property (
    @(posedge clk_sys) $past(srst) |-> p0_drv.oe_n == 8'hff)
    else $error("first port driven after reset");
  bus_addr_drive_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !$past(srst) && $past(bus.ale) |-> p0_drv.oe_n == 8'h00 &&
    p0_drv.dout == $past(bus.addr_low))
    else $error("address not driven while strobe high");
  p1_reset_high_a: assert property (
    @(posedge clk_sys) $past(srst) |->
    p1_drv.pulldown_n == 8'hff && p1_drv.weak_pu == 8'hff)
    else $error("second port not released at reset");
  p2_reset_high_a: assert property (
    @(posedge clk_sys) $past(srst) |-> p2_drv.pulldown_n == 8'hff)
    else $error("third port not high at reset");
  pulldown_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    p1_wr && !p1_wdata[5] |=> !p1_drv.pulldown_n[5] ##1
    ($past(p1_wr) || !p1_drv.pulldown_n[5]))
    else $error("pulldown not held");
  latch_pulldown_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !p1_latch[5] |-> !p1_drv.pulldown_n[5])
    else $error("pulldown off while latch holds zero");
  boost_pulse_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    p2_wr && !p2_latch[6] && p2_wdata[6] && !bus.ext_access |=>
    !p2_drv.boost_n[6])
    else $error("no boost on zero to one");
  boost_ends_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    int'(boost_run_r) <= BOOST_CYC)
    else $error("boost too long");
  rise_irq_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(in1_r[QBIO_IRQ_B]) && !$past(srst) |=> ext_irq_b_rising)
    else $error("rising irq missed");
  fall_irq_c_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $fell(in1_r[QBIO_IRQ_C]) && !$past(srst) |=> ext_irq_c_falling)
    else $error("falling irq c missed");
  rise_irq_d_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(in1_r[QBIO_IRQ_D]) && !$past(srst) |=> ext_irq_d_rising)
    else $error("rising irq d missed");
  fall_irq_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    $fell(in1_r[QBIO_IRQ_E]) && !$past(srst) |=> ext_irq_e_falling)
    else $error("falling irq missed");
  open_drain_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !$past(bus.ale) && !$past(bus.drive_data) |-> p0_drv.dout == 8'h00)
    else $error("first port drives a one outside the bus");
  addr_high_out_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    bus.ext_access && !p2_wr && p2_latch == 8'hff |=>
    p2_drv.pulldown_n == $past(bus.addr_high))
    else $error("upper address byte not on third port");
  p1_read_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !$past(srst) |-> p1_rd == $past(p1_in))
    else $error("second port read not the pin level");

  c_wr0: cover property (@(posedge clk_sys) p1_wr && p1_wdata == 8'h00);
  c_boost: cover property (@(posedge clk_sys) !p2_drv.boost_n[0]);
  c_bus: cover property (@(posedge clk_sys) bus.ale ##1 bus.drive_data);
  c_irq: cover property (@(posedge clk_sys) ext_irq_b_rising);
  c_open: cover property (@(posedge clk_sys) p0_wr && p0_wdata != 8'hff);
endmodule
`default_nettype wire

// >>> src/qbio_pkg.sv
// package: constants and carriers for the quasi-bidirectional port block
package qbio_pkg;
  localparam logic [7:0] QBIO_LATCH_RST = 8'hff;
  localparam int         QBIO_BOOST_CYC = 1;
  localparam int         QBIO_BOOST_W   = 4;
  localparam int         QBIO_T2_IO     = 0;
  localparam int         QBIO_T2_TRIG   = 1;
  localparam int         QBIO_RX        = 2;
  localparam int         QBIO_TX        = 3;
  localparam int         QBIO_IRQ_B     = 4;
  localparam int         QBIO_IRQ_C     = 5;
  localparam int         QBIO_IRQ_D     = 6;
  localparam int         QBIO_IRQ_E     = 7;

  // pin drive pair; enables low while the module drives
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } qbio_drv_t;

  // quasi-bidirectional pin: strong low, strong high boost, weak pullup
  typedef struct packed {
    logic [7:0] pulldown_n;
    logic [7:0] boost_n;
    logic [7:0] weak_pu;
  } qbio_qdrv_t;

  typedef struct packed {
    logic       ale;
    logic       drive_data;
    logic [7:0] addr_low;
    logic [7:0] wdata;
    logic [7:0] addr_high;
    logic       ext_access;
  } qbio_bus_t;
endpackage

// >>> src/qbio_qport.sv
// one 8-bit quasi-bidirectional port with latch and transition boost
`timescale 1ns/100ps
`default_nettype none
module qbio_qport #(
  parameter int BOOST_CYC = 1
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              wr,
  input  wire logic [7:0]        wdata,
  input  wire logic [7:0]        alt_low,
  input  wire logic [7:0]        pin_in,
  output logic [7:0]             latch,
  output logic [7:0]             rd_level,
  output qbio_pkg::qbio_qdrv_t   drv
);
  import qbio_pkg::*;
  logic [7:0]              latch_r, latch_nxt;
  logic [QBIO_BOOST_W-1:0] cnt_r [8];
  logic [QBIO_BOOST_W-1:0] cnt_nxt [8];
  qbio_qdrv_t              drv_r, drv_nxt;
  logic [7:0]              eff;

  always_comb begin
    latch_nxt = wr ? wdata : latch_r;
    eff = latch_nxt & ~alt_low;
    for (int i = 0; i < 8; i++) begin
      cnt_nxt[i] = (cnt_r[i] != '0) ? cnt_r[i] - 1'b1 : cnt_r[i];
      if (wr && !latch_r[i] && wdata[i])
        cnt_nxt[i] = QBIO_BOOST_W'(BOOST_CYC);
    end
    for (int i = 0; i < 8; i++) begin
      drv_nxt.pulldown_n[i] = eff[i];
      drv_nxt.boost_n[i]    = !(eff[i] && cnt_nxt[i] != '0);
      drv_nxt.weak_pu[i]    = eff[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_r <= QBIO_LATCH_RST;
      for (int i = 0; i < 8; i++)
        cnt_r[i] <= '0;
      drv_r <= '{pulldown_n: 8'hff, boost_n: 8'hff, weak_pu: 8'hff};
    end else begin
      latch_r <= latch_nxt;
      cnt_r   <= cnt_nxt;
      drv_r   <= drv_nxt;
    end
  end

  assign latch    = latch_r;
  assign rd_level = pin_in;
  assign drv      = drv_r;
endmodule
`default_nettype wire

// >>> bench/qbio_board.sv
// board model: pin levels from port drives and external circuits
`timescale 1ns/100ps
`default_nettype none
module qbio_board (
  input  wire qbio_pkg::qbio_drv_t  p0_drv,
  input  wire qbio_pkg::qbio_qdrv_t p1_drv,
  input  wire qbio_pkg::qbio_qdrv_t p2_drv,
  input  wire logic                 p0_ext_en,
  input  wire logic [7:0]           p0_ext_val,
  input  wire logic [7:0]           p1_low,
  input  wire logic [7:0]           p2_low,
  output logic [7:0]                p0_in,
  output logic [7:0]                p1_in,
  output logic [7:0]                p2_in
);
  import qbio_pkg::*;
  // undriven first-port bits rest on board pullups
  assign p0_in = (~p0_drv.oe_n & p0_drv.dout) |
                 (p0_drv.oe_n & (p0_ext_en ? p0_ext_val : 8'hff));
  // external low beats the weak pullup and the boost alike
  assign p1_in = p1_drv.pulldown_n & ~p1_low &
                 (p1_drv.weak_pu | ~p1_drv.boost_n);
  assign p2_in = p2_drv.pulldown_n & ~p2_low &
                 (p2_drv.weak_pu | ~p2_drv.boost_n);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the three-port pin block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import qbio_pkg::*;
  localparam int BC = 2;
  logic       clk_sys, srst, p0_wr, p1_wr, p2_wr, tx, t2_en, t2_o;
  logic       p0_ext_en, t2_io, t2_trig, rx, ib, ic, id, ie;
  logic [7:0] p0_wdata, p1_wdata, p2_wdata, p1_low, p2_low, p0_ext_val;
  logic [7:0] p0_in, p1_in, p2_in, p0_rd, p1_rd, p2_rd, ad_low;
  logic [3:0] seen;
  qbio_bus_t  bus;
  qbio_drv_t  p0_drv;
  qbio_qdrv_t p1_drv, p2_drv;
  int         n_mismatch = 0;
  int         total_checks = 0;
  `define CK(g, e) chk(24'(g), 24'(e))

  qbio_ports #(.BOOST_CYC(BC)) i_qbio_ports (.clk_sys(clk_sys),
    .srst(srst), .p0_wr(p0_wr), .p0_wdata(p0_wdata), .p1_wr(p1_wr),
    .p1_wdata(p1_wdata), .p2_wr(p2_wr), .p2_wdata(p2_wdata), .bus(bus),
    .serial1_transmit_out(tx), .timer2_out_en(t2_en), .timer2_out(t2_o),
    .p0_in(p0_in), .p1_in(p1_in), .p2_in(p2_in), .p0_drv(p0_drv),
    .p1_drv(p1_drv), .p2_drv(p2_drv), .p0_rd(p0_rd), .p1_rd(p1_rd),
    .p2_rd(p2_rd), .muxed_addr_data_low(ad_low), .timer2_ext_io(t2_io),
    .timer2_capture_reload_trigger(t2_trig), .serial1_receive_in(rx),
    .ext_irq_b_rising(ib), .ext_irq_c_falling(ic),
    .ext_irq_d_rising(id), .ext_irq_e_falling(ie));
  qbio_board i_qbio_board (.p0_drv(p0_drv), .p1_drv(p1_drv),
    .p2_drv(p2_drv), .p0_ext_en(p0_ext_en), .p0_ext_val(p0_ext_val),
    .p1_low(p1_low), .p2_low(p2_low), .p0_in(p0_in), .p1_in(p1_in),
    .p2_in(p2_in));

  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // both quasi ports written together to halve the stimulus
  task automatic wr(input logic [7:0] d);
    {p1_wr, p2_wr, p1_wdata, p2_wdata} = {2'b11, d, d};
    cyc(1);
    {p1_wr, p2_wr} = 2'b00;
  endtask
  task automatic t_reset();
    `CK(p0_drv, 16'h00ff);
    `CK(p1_drv, 24'hffffff);
    `CK(p2_drv, 24'hffffff);
    `CK({p1_rd, p2_rd}, 16'hffff);
  endtask
  task automatic t_write();
    wr(8'h00);
    `CK(p1_drv.pulldown_n, 8'h00);
    `CK(p2_drv.pulldown_n, 8'h00);
    cyc(3);
    `CK({p1_drv.pulldown_n, p1_rd, p2_rd}, 24'h0);
    wr(8'hff);
    for (int i = 0; i < BC; i++) begin
      `CK({p1_drv.boost_n, p2_drv.boost_n}, 16'h0);
      cyc(1);
    end
    `CK({p1_drv.boost_n, p2_drv.boost_n}, 16'hffff);
    `CK({p1_drv.weak_pu, p1_drv.pulldown_n}, 16'hffff);
    // a one over a one needs no boost
    wr(8'hff);
    `CK(p1_drv.boost_n, 8'hff);
  endtask
  task automatic t_alt();
    p1_low = 8'h07;
    cyc(3);
    `CK(p1_rd, 8'hf8);
    `CK({t2_io, t2_trig, rx}, 3'b000);
    p1_low = 8'h00;
    cyc(3);
    `CK({t2_io, t2_trig, rx}, 3'b111);
    tx = 1'b0;
    cyc(1);
    `CK(p1_drv.pulldown_n, 8'hf7);
    {tx, t2_en, t2_o} = 3'b110;
    cyc(1);
    `CK(p1_drv.pulldown_n, 8'hfe);
    t2_en = 1'b0;
  endtask
  task automatic edge_win(input logic [7:0] low);
    p1_low = low;
    seen = 4'h0;
    repeat (4) begin
      cyc(1);
      seen = seen | {ie, id, ic, ib};
    end
  endtask
  task automatic t_irq();
    edge_win(8'hf0);
    `CK(seen, 4'b1010);
    edge_win(8'h00);
    `CK(seen, 4'b0101);
  endtask
  // first port as plain I/O: zeros driven, ones left to board pullups
  task automatic t_p0();
    {p0_wr, p0_wdata} = {1'b1, 8'hf0};
    cyc(1);
    p0_wr = 1'b0;
    `CK(p0_drv, 16'h00f0);
    cyc(1);
    `CK({p0_rd, ad_low}, 16'hf0f0);
    {p0_wr, p0_wdata} = {1'b1, 8'hff};
    cyc(1);
    p0_wr = 1'b0;
    `CK(p0_drv, 16'h00ff);
  endtask
  task automatic t_bus();
    bus = '{ale: 1'b1, drive_data: 1'b0, addr_low: 8'ha5, wdata: 8'h3c,
            addr_high: 8'h96, ext_access: 1'b1};
    cyc(1);
    `CK(p0_drv, 16'ha500);
    `CK(p2_drv.pulldown_n, 8'h96);
    {bus.ale, bus.drive_data} = 2'b01;
    cyc(1);
    `CK(p0_drv, 16'h3c00);
    bus.drive_data = 1'b0;
    {p0_ext_en, p0_ext_val} = {1'b1, 8'h5a};
    cyc(2);
    `CK({p0_drv.oe_n, ad_low}, 16'hff5a);
    {bus.ext_access, p0_ext_en} = 2'b00;
    cyc(1);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {srst, p0_wr, p1_wr, p2_wr, tx, t2_en, t2_o, p0_ext_en} = 8'h88;
    {p0_wdata, p1_wdata, p2_wdata} = 24'hffffff;
    {p1_low, p2_low, p0_ext_val} = 24'h0;
    bus = '0;
    cyc(2);
    srst = 1'b0;
    t_reset();
    t_write();
    t_alt();
    t_irq();
    t_p0();
    t_bus();
    // reset again mid-run over latched zeros
    wr(8'h00);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
